// [design/pwp_defines.vh]
// Constants for the peripheral write-protect register bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef PWP_DEFINES_VH
`define PWP_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses)
`define PWP_CLEAR_OFFSET    12'h000
`define PWP_SET_OFFSET      12'h004
`define PWP_ADDR_WIDTH      12

// ==========================================================
// Reset values of the shared protection state
`define PWP_RESET_BANK_B    32'h00000002
`define PWP_RESET_BANK_C    32'h00000000

// ==========================================================
// Bit positions, first bridge layout
`define PWP_TRACE_BUFFER_BIT     6
`define PWP_PIN_PORT_BIT         3
`define PWP_FLASH_CTRL_BIT       2
`define PWP_DEBUG_UNIT_BIT       1
`define PWP_MASK_BANK_B          32'h0000004e

// ==========================================================
// Bit positions, further bridge layout
`define PWP_ANALOG_BIT           16
`define PWP_TIMER_MSB            15
`define PWP_TIMER_LSB            8
`define PWP_SERIAL_MSB           7
`define PWP_SERIAL_LSB           2
`define PWP_EVENT_SYSTEM_BIT     1
`define PWP_MASK_BANK_C          32'h0001fffe

`endif

// [design/pwp_bit.v]
// One protection bit shared by the set and clear registers.
// Assumes set and clear strobes are single-cycle write strobes.
`timescale 1ns/10ps
`default_nettype none

module pwp_bit #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire clk_sys,
    input  wire reset,
    input  wire set_pulse,
    input  wire clear_pulse,
    output reg  protect
);

    always @(posedge clk_sys) begin
        if (reset) begin
            protect <= RESET_VALUE;
        end else if (set_pulse) begin
            // Set wins if software writes both in one cycle
            protect <= 1'b1;
        end else if (clear_pulse) begin
            protect <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [design/pwp_top.v]
// Peripheral write-protect register bank behind an APB slave.
// Assumes one clock and a synchronous active-high reset.
// Assumes byte strobes are tied high by masters that do not use them.
// Layout of the further bridge is chosen through BIT_MASK and RESET_STATE.
`timescale 1ns/10ps
`default_nettype none
`include "pwp_defines.vh"

module pwp_top #(
    parameter [31:0] BIT_MASK    = `PWP_MASK_BANK_B,
    parameter [31:0] RESET_STATE = `PWP_RESET_BANK_B
) (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output wire [31:0] protect_state
);

    // ======================================================
    // Local constants
    localparam ADDR_WIDTH = `PWP_ADDR_WIDTH;
    localparam DATA_WIDTH = 32;
    localparam LANE_WIDTH = 8;
    localparam LANES      = DATA_WIDTH / LANE_WIDTH;

    // ======================================================
    // Address map
    // Byte addresses of the two views of the shared state
    localparam [ADDR_WIDTH-1:0] CLEAR_ADDR = `PWP_CLEAR_OFFSET;
    localparam [ADDR_WIDTH-1:0] SET_ADDR   = `PWP_SET_OFFSET;
    localparam [DATA_WIDTH-1:0] ZERO_WORD  = 32'h00000000;

    // ======================================================
    // Reset image
    // A reset one outside the mask would name a missing bit
    localparam [DATA_WIDTH-1:0] RESET_BITS = RESET_STATE & BIT_MASK;

    // ======================================================
    // Bus phase signals
    wire        setup_phase;
    wire        access_phase;
    wire        read_setup;
    wire        write_access;

    // ======================================================
    // Decode signals
    reg         hit_set;
    reg         hit_clear;
    wire        hit_any;
    wire        unmapped;
    wire        wr_set;
    wire        wr_clear;

    // ======================================================
    // Write data signals
    wire [31:0] byte_mask;
    wire [31:0] lane_data;
    wire [31:0] wr_bits;
    reg  [31:0] set_pulse;
    reg  [31:0] clear_pulse;

    // ======================================================
    // State and read signals
    wire [31:0] state;
    wire [31:0] protect_set_reg;
    wire [31:0] protect_clear_reg;
    reg  [31:0] read_word;
    reg  [31:0] next_prdata;

    // ======================================================
    // Bus phases
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign read_setup   = setup_phase & ~pwrite;
    assign write_access = access_phase & pwrite;

    // ======================================================
    // Handshake
    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;

    // ======================================================
    // Address decode
    // Exact match on the whole address, so no aliases appear in the map
    // set at 0x04
    always @* begin
        hit_set   = 1'b0;
        hit_clear = 1'b0;
        if (paddr == SET_ADDR) begin
            hit_set = 1'b1;
        end else if (paddr == CLEAR_ADDR) begin
            hit_clear = 1'b1;
        end
    end

    assign hit_any  = hit_set | hit_clear;
    assign unmapped = ~hit_any;

    // ======================================================
    // Error response
    // Unmapped words answer with an error and change nothing
    assign pslverr = access_phase & unmapped;

    // ======================================================
    // Write strobes
    assign wr_set   = write_access & hit_set;
    assign wr_clear = write_access & hit_clear;

    // ======================================================
    // Byte lanes
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            assign byte_mask[lane*LANE_WIDTH +: LANE_WIDTH] =
                {LANE_WIDTH{pstrb[lane]}};
        end
    endgenerate

    assign lane_data = pwdata & byte_mask;

    // ======================================================
    // Write data qualification
    // zeros ignored
    assign wr_bits = lane_data & BIT_MASK;

    // ======================================================
    // Set and clear pulses
    // One address per access, so set and clear never fire together
    always @* begin
        set_pulse = ZERO_WORD;
        if (wr_set) begin
            set_pulse = wr_bits;
        end
    end

    always @* begin
        clear_pulse = ZERO_WORD;
        if (wr_clear) begin
            clear_pulse = wr_bits;
        end
    end

    // ======================================================
    // Protection state
    // debug bit protected
    genvar i;
    generate
        for (i = 0; i < DATA_WIDTH; i = i + 1) begin : g_bit
            if (BIT_MASK[i]) begin : g_used
                pwp_bit #(
                    .RESET_VALUE (RESET_BITS[i])
                ) u_bit (
                    .clk_sys     (clk_sys),
                    .reset       (reset),
                    .set_pulse   (set_pulse[i]),
                    .clear_pulse (clear_pulse[i]),
                    .protect     (state[i])
                );
            end else begin : g_unused
                // Unimplemented positions read as zero
                assign state[i] = 1'b0;
            end
        end
    endgenerate

    // ======================================================
    // Live protection output
    assign protect_state = state;

    // ======================================================
    // Register views
    // shared state read
    assign protect_set_reg   = state;
    assign protect_clear_reg = state;

    // ======================================================
    // Read data
    always @* begin
        read_word = ZERO_WORD;
        if (hit_set) begin
            read_word = protect_set_reg;
        end else if (hit_clear) begin
            read_word = protect_clear_reg;
        end
    end

    // Loaded in the setup cycle so the word stands through the access
    always @* begin
        next_prdata = prdata;
        if (read_setup) begin
            next_prdata = read_word;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            prdata <= ZERO_WORD;
        end else begin
            prdata <= next_prdata;
        end
    end

endmodule

`default_nettype wire

// [bench/pwp_chk.sv]
// Checker for pwp_top ports, bound below.
// Assumes one clock; byte strobes gate the written lanes.
`timescale 1ns/10ps
`default_nettype none
module pwp_chk #(parameter [31:0] BIT_MASK = 32'h4e, RESET_STATE = 32'h2) (
    input wire logic        clk_sys, reset, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] pwdata, protect_state
);
    // Byte lanes enabled by the strobes of the current access
    wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                             {8{pstrb[1]}}, {8{pstrb[0]}}};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Write access ending here
    sequence s_wr; psel && penable && pwrite; endsequence
    property p_zero; s_wr ##0 pwdata == 32'h0 |=> $stable(protect_state);
    endproperty
    property p_set; s_wr ##0 paddr == 12'h004 |=> protect_state ==
        ($past(protect_state) | $past(pwdata & strb_mask) & BIT_MASK);
    endproperty
    property p_clr; s_wr ##0 paddr == 12'h000 |=> protect_state ==
        ($past(protect_state) & ~$past(pwdata & strb_mask)); endproperty
    property p_rst; $fell(reset) |-> protect_state == RESET_STATE; endproperty
    property p_map; (protect_state & ~BIT_MASK) == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("zero write");
    a_clr: assert property (p_clr) else $error("clear");
    a_rst: assert property (p_rst) else $error("reset");
    a_map: assert property (p_map) else $error("stray bit");
    a_set: assert property (p_set) else $error("set");
endmodule
bind pwp_top pwp_chk #(.BIT_MASK(BIT_MASK), .RESET_STATE(RESET_STATE))
    u_chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pstrb(pstrb), .pwdata(pwdata), .protect_state(protect_state));
`default_nettype wire

// [bench/testbench.sv]
// Bench for pwp_top over its bus port.
// Assumes zero-wait answers.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata, protect_state;
    logic [3:0]  pstrb = 4'hf;
    logic        pslverr, err;
    int          bad_count = 0, comparisons = 0;
    pwp_top dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .protect_state);
    initial forever #5 clk_sys = ~clk_sys;
    task chk(input string n, input logic [31:0] e, g);
        comparisons++;
        bad_count += (g !== e);
        if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
    endtask
    // Request held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys) penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask
    // Read back via the other register
    task wr(input logic [11:0] a, input logic [31:0] d, e);
        apb(1'b1, a, d);
        chk("error", (a == 12'h000 || a == 12'h004) ? 32'h0 : 32'h1, err);
        chk("state", e, protect_state);
        apb(1'b0, 12'h004 & ~a, 32'h0);
        chk("readback", e, rd);
    endtask
    task t_set;
        wr(12'h000, 32'h0, 32'h2);
        wr(12'h004, 32'hffffffff, 32'h4e);
        wr(12'h004, 32'h0, 32'h4e);
    endtask
    task t_clear;
        wr(12'h000, 32'h4, 32'h4a);
        wr(12'h008, 32'h8, 32'h4a);
        wr(12'h000, 32'hffffffff, 32'h0);
    endtask
    // Disabled byte lanes leave their bits alone
    task t_strobe;
        pstrb <= 4'he;
        wr(12'h004, 32'hffffffff, 32'h0);
        pstrb <= 4'h1;
        wr(12'h004, 32'hffffffff, 32'h4e);
        pstrb <= 4'h2;
        wr(12'h000, 32'hffffffff, 32'h4e);
        pstrb <= 4'hf;
    endtask
    task t_reset;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("reset state", 32'h2, protect_state);
        chk("reset read", 32'h0, prdata);
        wr(12'h004, 32'h8, 32'ha);
    endtask
    task t_unmapped;
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("read error", 32'h1, err);
    endtask
    task end_of_test;
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_set;
        t_clear;
        t_strobe;
        t_reset;
        t_unmapped;
        end_of_test;
    end
    initial begin
        #20000 bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
